// ### rcri_top.sv
// module: reset-class register initialisation with an AXI4-Lite register slave
// How it works
// - an interrupt wake-up with either global enable set loads the pc with 0008h or 0018h.
// - on that wake-up the current pc is copied into the upper, high and low stack-top bytes.
// - on that wake-up the return stack pointer moves on to the next stack location, but holds once it is at 1Fh.
// - every wake-up sets the flag bit of the source that caused it.
// - bit 6 of the first port's pins, latch and direction exists only in ext-clock-io or rc-io modes.
// - the long-write enable is cleared by power-on reset, by the external reset pin, or by a control write with bit 2 clear.
// - every unimplemented bit reads as zero.
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module rcri_top
    import rcri_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // reset and wake sources
    input wire logic bor_evt,
    input wire logic external_reset_pin_n,
    input wire logic wdt_rst,
    input wire logic instr_rst,
    input wire logic stack_rst,
    input wire logic wake_wdt,
    input wire logic wake_irq,
    input wire logic wake_irq_high,
    input wire logic [rcri_pkg::SRC_W-1:0] wake_src,
    // first port pins
    input wire logic [7:0] first_port_pins,
    output logic [7:0] first_port_latch,
    output logic [7:0] first_port_direction,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rcri_pkg::*;

    // ************************************
    // pin synchronisers
    // ************************************
    logic external_reset_pin_meta_r, external_reset_pin_sync_r;
    logic [7:0] pins_meta_r, pins_sync_r;

    always_ff @(posedge mclk)
    begin
        external_reset_pin_meta_r <= external_reset_pin_n;
        external_reset_pin_sync_r <= external_reset_pin_meta_r;
        pins_meta_r <= first_port_pins;
        pins_sync_r <= pins_meta_r;
    end

    // ************************************
    // reset classification
    // ************************************
    rcri_evt_if evt ();

    // rst_n acts as the power-on reset of the core
    rcri_classify u_cls (
        .por_evt(~rst_n),
        .bor_evt(bor_evt),
        .external_reset_pin_low(~external_reset_pin_sync_r),
        .wdt_rst(wdt_rst),
        .instr_rst(instr_rst),
        .stack_rst(stack_rst),
        .wake_wdt(wake_wdt),
        .wake_irq(wake_irq),
        .evt(evt)
    );

    // ************************************
    // core state
    // ************************************
    logic high_prio_global_irq_enable_r, high_prio_global_irq_enable_nxt, low_prio_global_irq_enable_r, low_prio_global_irq_enable_nxt, lwrt_r, lwrt_nxt;
    logic [OSC_W-1:0] osc_r, osc_nxt;
    logic [PC_W-1:0] pc_r, pc_nxt, tos_r, tos_nxt;
    logic [SP_W-1:0] sp_r, sp_nxt;
    logic [7:0] latch_r, latch_nxt, dir_r, dir_nxt;
    logic [FLAG_W-1:0] flags_r, flags_nxt;
    rcri_class_e last_r, last_nxt;
    logic [7:0] port_mask;
    logic wr_go;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;

    // pin 6 only lives when the oscillator leaves it free
    always_comb
    begin
        port_mask = PORT_ALL;
        if (osc_r != OSC_EXT_CLOCK_IO && osc_r != OSC_RC_IO)
        begin
            port_mask[PORT_FREE_BIT] = 1'b0;
        end
    end

    always_comb
    begin
        high_prio_global_irq_enable_nxt = high_prio_global_irq_enable_r;
        low_prio_global_irq_enable_nxt = low_prio_global_irq_enable_r;
        lwrt_nxt = lwrt_r;
        osc_nxt = osc_r;
        pc_nxt = pc_r;
        tos_nxt = tos_r;
        sp_nxt = sp_r;
        latch_nxt = latch_r;
        dir_nxt = dir_r;
        flags_nxt = flags_r;
        last_nxt = last_r;
        // software writes first, so hardware events below win
        if (wr_go && wr_addr == ADDR_CTRL)
        begin
            high_prio_global_irq_enable_nxt = wr_data[CTRL_HIGH_PRIO_GLOBAL_IRQ_ENABLE];
            low_prio_global_irq_enable_nxt = wr_data[CTRL_LOW_PRIO_GLOBAL_IRQ_ENABLE];
            lwrt_nxt = wr_data[CTRL_LWRT];
            osc_nxt = wr_data[CTRL_OSC_LO +: OSC_W];
        end
        if (wr_go && wr_addr == ADDR_PC)
        begin
            pc_nxt = wr_data[PC_W-1:0];
        end
        if (wr_go && wr_addr == ADDR_PORT)
        begin
            latch_nxt = wr_data[7:0] & port_mask;
            dir_nxt = wr_data[PORT_DIR_LO +: 8] & port_mask;
        end
        if (wr_go && wr_addr == ADDR_FLAGS)
        begin
            flags_nxt = flags_r & ~wr_data[FLAG_W-1:0];
        end
        if (evt.cls != RCRI_CLS_NONE)
        begin
            last_nxt = evt.cls;
        end
        if (evt.lwrt_clr)
        begin
            lwrt_nxt = 1'b0;
        end
        case (evt.cls)
            RCRI_CLS_POWER:
            begin
                // oscillator mode is set by control writes; no class touches it here, only rst_n reloads it with rc-io
                high_prio_global_irq_enable_nxt = 1'b0;
                low_prio_global_irq_enable_nxt = 1'b0;
                pc_nxt = PC_RESET;
                tos_nxt = PC_RESET;
                sp_nxt = SP_RESET;
                latch_nxt = LATCH_RESET;
                dir_nxt = DIR_RESET & port_mask;
                flags_nxt = '0;
            end
            RCRI_CLS_PIN:
            begin
                high_prio_global_irq_enable_nxt = 1'b0;
                low_prio_global_irq_enable_nxt = 1'b0;
                pc_nxt = PC_RESET;
                tos_nxt = PC_RESET;
                sp_nxt = SP_RESET;
                dir_nxt = DIR_RESET & port_mask;
                flags_nxt = '0;
            end
            RCRI_CLS_WAKE:
            begin
                flags_nxt[wake_src] = 1'b1;
                if (evt.wake_irq && (high_prio_global_irq_enable_r || low_prio_global_irq_enable_r))
                begin
                    tos_nxt = pc_r;
                    if (sp_r != SP_MAX)
                    begin
                        sp_nxt = sp_r + 5'h01;
                    end
                    pc_nxt = wake_irq_high ? VEC_HIGH : VEC_LOW;
                end
                else
                begin
                    pc_nxt = pc_r + PC_STEP;
                end
            end
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            osc_r <= OSC_RC_IO;
        end
        else
        begin
            osc_r <= osc_nxt;
        end
        // power class is forced by rst_n through the classifier
        high_prio_global_irq_enable_r <= high_prio_global_irq_enable_nxt;
        low_prio_global_irq_enable_r <= low_prio_global_irq_enable_nxt;
        lwrt_r <= lwrt_nxt;
        pc_r <= pc_nxt;
        tos_r <= tos_nxt;
        sp_r <= sp_nxt;
        latch_r <= latch_nxt;
        dir_r <= dir_nxt;
        flags_r <= flags_nxt;
        last_r <= last_nxt;
    end

    assign first_port_latch = latch_r & port_mask;
    assign first_port_direction = dir_r & port_mask;

    // ************************************
    // axi4-lite slave
    // ************************************
    logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt, bvalid_r, bvalid_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [7:0] awaddr_r, awaddr_nxt;
    logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic wr_hit, rd_hit;
    logic aw_have, w_have;
    logic [31:0] rd_word;

    assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
    assign s_axi_wready = ~w_hold_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign wr_addr = awaddr_nxt;
    assign wr_data = wdata_nxt;
    // whole-word writes only; byte strobes are accepted but not split
    // built from held state and this cycle's takes, not from the _nxt values it clears
    assign aw_have = aw_hold_r | (s_axi_awvalid & s_axi_awready);
    assign w_have = w_hold_r | (s_axi_wvalid & s_axi_wready);
    assign wr_go = aw_have & w_have & ~bvalid_r;
    assign wr_hit = wr_addr == ADDR_CTRL || wr_addr == ADDR_PC || wr_addr == ADDR_PORT
        || wr_addr == ADDR_FLAGS;

    always_comb
    begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            ADDR_CTRL:
            begin
                rd_word[CTRL_HIGH_PRIO_GLOBAL_IRQ_ENABLE] = high_prio_global_irq_enable_r;
                rd_word[CTRL_LOW_PRIO_GLOBAL_IRQ_ENABLE] = low_prio_global_irq_enable_r;
                rd_word[CTRL_LWRT] = lwrt_r;
                rd_word[CTRL_OSC_LO +: OSC_W] = osc_r;
            end
            ADDR_PC: rd_word[PC_W-1:0] = pc_r;
            ADDR_STACK:
            begin
                rd_word[PC_W-1:0] = tos_r;
                rd_word[STACK_SP_LO +: SP_W] = sp_r;
            end
            ADDR_PORT:
            begin
                rd_word[7:0] = latch_r & port_mask;
                rd_word[PORT_DIR_LO +: 8] = dir_r & port_mask;
                rd_word[PORT_PIN_LO +: 8] = pins_sync_r & port_mask;
            end
            ADDR_FLAGS: rd_word[FLAG_W-1:0] = flags_r;
            ADDR_CLASS: rd_word[1:0] = last_r;
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb
    begin
        aw_hold_nxt = aw_hold_r;
        w_hold_nxt = w_hold_r;
        awaddr_nxt = awaddr_r;
        wdata_nxt = wdata_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_hold_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_hold_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
        end
        if (wr_go)
        begin
            aw_hold_nxt = 1'b0;
            w_hold_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_r && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt = rd_word;
            rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_r && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            bresp_r <= RESP_OKAY;
            rresp_r <= RESP_OKAY;
        end
        else
        begin
            aw_hold_r <= aw_hold_nxt;
            w_hold_r <= w_hold_nxt;
            bvalid_r <= bvalid_nxt;
            rvalid_r <= rvalid_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule

// ### rcri_pkg.sv
// package: constants, register map and reset classes of the reset-class register init block
package rcri_pkg;

    // ************************************
    // widths
    // ************************************
    localparam int PC_W = 21;
    localparam int SP_W = 5;
    localparam int FLAG_W = 16;
    localparam int SRC_W = 4;
    localparam int OSC_W = 3;

    // ************************************
    // reset classes
    // ************************************
    typedef enum logic [1:0] {
        RCRI_CLS_NONE = 2'h0,
        RCRI_CLS_POWER = 2'h1,
        RCRI_CLS_PIN = 2'h3,
        RCRI_CLS_WAKE = 2'h2
    } rcri_class_e;

    // ************************************
    // program counter and vectors
    // ************************************
    localparam logic [PC_W-1:0] PC_RESET = 21'h0_0000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
    localparam logic [PC_W-1:0] VEC_HIGH = 21'h0_0008;
    localparam logic [PC_W-1:0] VEC_LOW = 21'h0_0018;
    localparam logic [SP_W-1:0] SP_RESET = 5'h00;
    localparam logic [SP_W-1:0] SP_MAX = 5'h1F;

    // ************************************
    // oscillator modes that free port bit 6
    // ************************************
    localparam logic [OSC_W-1:0] OSC_EXT_CLOCK_IO = 3'h4;
    localparam logic [OSC_W-1:0] OSC_RC_IO = 3'h6;
    localparam int PORT_FREE_BIT = 6;
    localparam logic [7:0] PORT_ALL = 8'hFF;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;

    // ************************************
    // register map (byte addresses)
    // ************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PC = 8'h04;
    localparam logic [7:0] ADDR_STACK = 8'h08;
    localparam logic [7:0] ADDR_PORT = 8'h0C;
    localparam logic [7:0] ADDR_FLAGS = 8'h10;
    localparam logic [7:0] ADDR_CLASS = 8'h14;

    // ctrl fields
    localparam int CTRL_HIGH_PRIO_GLOBAL_IRQ_ENABLE = 0;
    localparam int CTRL_LOW_PRIO_GLOBAL_IRQ_ENABLE = 1;
    localparam int CTRL_LWRT = 2;
    localparam int CTRL_OSC_LO = 4;
    // stack fields
    localparam int STACK_SP_LO = 24;
    // port fields
    localparam int PORT_DIR_LO = 8;
    localparam int PORT_PIN_LO = 16;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### rcri_evt_if.sv
// interface: classified reset event from the classifier to the register logic
`timescale 1ns/1ps
interface rcri_evt_if;
    import rcri_pkg::*;
    rcri_class_e cls;
    logic lwrt_clr;
    logic wake_irq;

    modport src (output cls, output lwrt_clr, output wake_irq);
    modport dst (input cls, input lwrt_clr, input wake_irq);
endinterface

// ### rcri_classify.sv
// module: sorts the reset and wake-up sources into one reset class per cycle
`timescale 1ns/1ps
module rcri_classify
    import rcri_pkg::*;
(
    // power class sources
    input wire logic por_evt,
    input wire logic bor_evt,
    // pin class sources
    input wire logic external_reset_pin_low,
    input wire logic wdt_rst,
    input wire logic instr_rst,
    input wire logic stack_rst,
    // wake sources
    input wire logic wake_wdt,
    input wire logic wake_irq,
    // result
    rcri_evt_if.src evt
);

    // ************************************
    // priority: power over pin over wake
    // ************************************
    always_comb
    begin
        evt.wake_irq = 1'b0;
        evt.lwrt_clr = por_evt | external_reset_pin_low;
        if (por_evt | bor_evt)
        begin
            evt.cls = RCRI_CLS_POWER;
        end
        else if (external_reset_pin_low | wdt_rst | instr_rst | stack_rst)
        begin
            evt.cls = RCRI_CLS_PIN;
        end
        else if (wake_wdt | wake_irq)
        begin
            evt.cls = RCRI_CLS_WAKE;
            evt.wake_irq = wake_irq;
        end
        else
        begin
            evt.cls = RCRI_CLS_NONE;
        end
    end

endmodule

// ### rcri_top_chk.sv
// checker: bus handshake and reset-value properties seen at the block's ports
`timescale 1ns/1ps
module rcri_top_chk
    import rcri_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // port outputs
    input wire logic [7:0] first_port_latch,
    input wire logic [7:0] first_port_direction,
    // register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid
);
    // ************************************
    // properties
    // ************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire rd_take = s_axi_arvalid && s_axi_arready;

    wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    rd_unmapped_a: assert property (rd_take && s_axi_araddr > ADDR_CLASS |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    wr_unmapped_a: assert property (wr_take && s_axi_awaddr > ADDR_CLASS |=>
        s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    ctrl_zeros_a: assert property (rd_take && s_axi_araddr == ADDR_CTRL |=>
        (s_axi_rdata & 32'hFFFF_FF88) == 32'h0000_0000)
        else $error("control spare bits not zero");
    stack_zeros_a: assert property (rd_take && s_axi_araddr == ADDR_STACK |=>
        (s_axi_rdata & 32'hE0E0_0000) == 32'h0000_0000)
        else $error("stack spare bits not zero");
    port_init_a: assert property ($rose(rst_n) |->
        first_port_direction == 8'hFF && first_port_latch == 8'h00)
        else $error("port reset values wrong");
endmodule

bind rcri_top rcri_top_chk i_rcri_top_chk (.mclk(mclk), .rst_n(rst_n),
    .first_port_latch(first_port_latch), .first_port_direction(first_port_direction),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid));

// ### rcri_top_tb_top.sv
// testbench: reset-class register init, driven over its ports and register bus
`timescale 1ns/1ps
module rcri_top_tb_top;
    import rcri_pkg::*;
    logic mclk, rst_n, bor_evt, external_reset_pin_n, wdt_rst, instr_rst, stack_rst;
    logic wake_wdt, wake_irq, wake_irq_high;
    logic [3:0] wake_src;
    logic [7:0] pins, latch, dir, awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int errors;
    int n_compared;

    rcri_top i_rcri_top (.mclk(mclk), .rst_n(rst_n), .bor_evt(bor_evt),
        .external_reset_pin_n(external_reset_pin_n), .wdt_rst(wdt_rst), .instr_rst(instr_rst),
        .stack_rst(stack_rst), .wake_wdt(wake_wdt), .wake_irq(wake_irq),
        .wake_irq_high(wake_irq_high), .wake_src(wake_src), .first_port_pins(pins),
        .first_port_latch(latch), .first_port_direction(dir), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ************************************
    // bus and compare tasks
    // ************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, g);
            errors++;
        end
    endtask

    // waits on the answer, never on a cycle count; the watchdog cuts a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid)
            begin
                r = bresp;
                break;
            end
        end
        bready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid)
            begin
                v = rdata;
                r = rresp;
                break;
            end
        end
        rready <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a, d, rsp);
        chk(n, e, d);
    endtask

    task automatic wake(input logic irq, input logic hi, input logic [3:0] src);
        wake_irq <= irq;
        wake_wdt <= ~irq;
        wake_irq_high <= hi;
        wake_src <= src;
        @(posedge mclk);
        wake_irq <= 1'b0;
        wake_wdt <= 1'b0;
        @(posedge mclk);
    endtask

    // the pin source goes through a synchroniser, so every source is held three edges
    task automatic src_hit(input int k);
        case (k)
            0: wdt_rst <= 1'b1;
            1: bor_evt <= 1'b1;
            2: instr_rst <= 1'b1;
            3: stack_rst <= 1'b1;
            default: external_reset_pin_n <= 1'b0;
        endcase
        repeat (3) @(posedge mclk);
        {wdt_rst, bor_evt, instr_rst, stack_rst, external_reset_pin_n} <= 5'b00001;
        repeat (5) @(posedge mclk);
    endtask

    task automatic results;
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ************************************
    // scenarios
    // ************************************
    task automatic t_reset;
        rc(ADDR_CTRL, 32'h0000_0060, "ctrl");
        rc(ADDR_PC, 32'h0000_0000, "pc");
        rc(ADDR_STACK, 32'h0000_0000, "stack");
        rc(ADDR_PORT, 32'h005A_FF00, "port");
        rc(ADDR_FLAGS, 32'h0000_0000, "flags");
        rc(ADDR_CLASS, 32'h0000_0001, "class");
    endtask

    task automatic t_masks;
        wr(ADDR_CTRL, 32'hFFFF_FFFF, rsp);
        rc(ADDR_CTRL, 32'h0000_0077, "ctrl spare");
        wr(ADDR_PORT, 32'hFFFF_FFFF, rsp);
        chk("latch", 8'hBF, latch);
        chk("dir", 8'hBF, dir);
        rc(ADDR_PORT, 32'h001A_BFBF, "port masked");
        wr(ADDR_CTRL, 32'h0000_0047, rsp);
        wr(ADDR_PORT, 32'h0000_FFFF, rsp);
        chk("latch", 8'hFF, latch);
        rc(ADDR_PORT, 32'h005A_FFFF, "port free");
        rc(8'h18, 32'h0000_0000, "unmapped");
        chk("rresp", RESP_SLVERR, rsp);
        wr(8'h1C, 32'h1234_5678, rsp);
        chk("bresp", RESP_SLVERR, rsp);
    endtask

    task automatic t_irq;
        wr(ADDR_PC, 32'h0000_1234, rsp);
        wake(1'b1, 1'b1, 4'h3);
        rc(ADDR_PC, VEC_HIGH, "pc high");
        rc(ADDR_STACK, 32'h0100_1234, "stack");
        rc(ADDR_FLAGS, 32'h0000_0008, "flags");
        rc(ADDR_CLASS, 32'h0000_0002, "class");
        wake(1'b1, 1'b0, 4'hF);
        rc(ADDR_PC, VEC_LOW, "pc low");
        rc(ADDR_STACK, 32'h0200_0008, "stack");
        rc(ADDR_FLAGS, 32'h0000_8008, "flags");
        wr(ADDR_FLAGS, 32'h0000_FFFF, rsp);
        rc(ADDR_FLAGS, 32'h0000_0000, "flags clr");
    endtask

    task automatic t_nogie;
        wr(ADDR_CTRL, 32'h0000_0044, rsp);
        wake(1'b1, 1'b1, 4'h0);
        rc(ADDR_PC, 32'h0000_001A, "pc step");
        rc(ADDR_STACK, 32'h0200_0008, "stack kept");
        wake(1'b0, 1'b0, 4'h5);
        rc(ADDR_PC, 32'h0000_001C, "pc wdt");
        rc(ADDR_FLAGS, 32'h0000_0021, "flags");
    endtask

    task automatic t_classes;
        logic [31:0] ctrl_e[5] = '{32'h0000_0044, 32'h0000_0044, 32'h0000_0044,
            32'h0000_0044, 32'h0000_0040};
        logic [31:0] cls_e[5] = '{32'h0000_0003, 32'h0000_0001, 32'h0000_0003,
            32'h0000_0003, 32'h0000_0003};
        for (int k = 0; k < 5; k++)
        begin
            wr(ADDR_PC, 32'h0000_0040, rsp);
            src_hit(k);
            rc(ADDR_CTRL, ctrl_e[k], "ctrl");
            rc(ADDR_CLASS, cls_e[k], "class");
            rc(ADDR_PC, 32'h0000_0000, "pc");
            rc(ADDR_STACK, 32'h0000_0000, "stack");
            rc(ADDR_FLAGS, 32'h0000_0000, "flags");
        end
        chk("latch", 8'h00, latch);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        $display("BAD watchdog exp done got hang");
        errors++;
        results();
    end

    initial
    begin
        {rst_n, bor_evt, wdt_rst, instr_rst, stack_rst, wake_wdt, wake_irq} = 7'h00;
        {wake_irq_high, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        external_reset_pin_n = 1'b1;
        wake_src = 4'h0;
        pins = 8'h5A;
        {awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000F;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_reset();
        t_masks();
        t_irq();
        t_nogie();
        t_classes();
        results();
    end
endmodule
